/* design/nbm_dma.sv */
// Bus arbitration, local burst DMA, remote port DMA and register slave
// Function
// - After power-up the block is a slave in reset, receiver and transmitter off.
// - Stop command, hard reset or FIFO/ring errors return it to reset.
// - A start command moves it to idle; it idles until DMA is needed.
// - FIFO or remote request leaves idle, wins bus, transfers, returns idle.
// - Four transfer types: 16 or 32-bit address, 8 or 16-bit data.
// - Each transfer takes four bus clocks, address then data.
// - In 32-bit mode each burst first outputs the upper address page, except a local burst appended to a remote unit.
// - Upper address strobe driven only during the first cycle group.
// - A granted local burst moves the configured length (with fill set, until fifo_last_i), then releases.
// - Burst is 1,2,4,6 words or 2,4,8,12 bytes.
// - Next burst waits for FIFO threshold; option fills or empties completely.
// - Grant withdrawn during a transfer aborts the burst.
// - Local DMA has priority; remote resumes after re-arbitration.
// - FIFO need during remote keeps request; local to remote drops it.
// - Remote arbitrates per unit and moves one direction at a time.
// - Remote read fetches to latch, counts, raises port request; ack refetches.
// - Remote write: host writes latch, request drops, data stored, request again.
// - Request drops after each remote unit unless a local burst follows; remote waits out local DMA.
// - Slave access reaches byte-wide registers (REG_LADDR is 16-bit, REG_STAT reads 9 bits) with separate read/write.
// - Register address is captured at the start of the access.
// - Slave answer waits until not master and synchronised.
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
module nbm_dma
  import nbm_pkg::*;
#(
  parameter int SYNC_CYC = nbm_pkg::SYNC_CYC_DEF
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Register bus
  input wire logic [nbm_pkg::AVS_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [nbm_pkg::AVS_DW-1:0] avs_writedata_i,
  output logic [nbm_pkg::AVS_DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Bus arbitration
  output logic bus_request_o,
  input wire logic bus_grant_i,
  // Multiplexed memory bus
  input wire logic [nbm_pkg::BUS_W-1:0] muxed_addr_data_bus_i,
  output logic [nbm_pkg::BUS_W-1:0] muxed_addr_data_bus_o,
  output logic muxed_addr_data_bus_oe_o,
  output logic address_strobe_lower_o,
  output logic address_strobe_upper_o,
  output logic address_strobe_upper_oe_o,
  output logic memory_read_strobe_o,
  output logic memory_write_strobe_o,
  // FIFO side
  input wire logic fifo_req_i,
  input wire logic fifo_to_mem_i,
  input wire logic fifo_last_i,
  input wire logic fifo_error_i,
  input wire logic [nbm_pkg::BUS_W-1:0] fifo_rdata_i,
  output logic fifo_rd_o,
  output logic [nbm_pkg::BUS_W-1:0] fifo_wdata_o,
  output logic fifo_wr_o,
  output logic rx_enable_o,
  output logic tx_enable_o,
  // Remote port
  output logic port_request_o,
  input wire logic port_read_ack_i,
  input wire logic port_write_ack_i,
  input wire logic [nbm_pkg::BUS_W-1:0] port_wdata_i,
  output logic [nbm_pkg::BUS_W-1:0] port_rdata_o
);
  import nbm_pkg::*;

  if (SYNC_CYC < 2 || SYNC_CYC > 15)
  begin : g_chk
    $error("SYNC_CYC must lie in 2..15");
  end

  // ******************************
  // Helpers
  // ******************************
  function automatic logic [15:0] step(input logic wide);
    step = wide ? STEP_WORD : STEP_BYTE;
  endfunction

  function automatic logic [15:0] dec(input logic [15:0] n, input logic wide);
    dec = (n > step(wide)) ? n - step(wide) : '0;
  endfunction

  function automatic logic [15:0] lane(input logic [15:0] d, input logic wide);
    lane = wide ? d : {8'h00, d[7:0]};
  endfunction

  // ******************************
  // State
  // ******************************
  nbm_state_e state_r, state_nxt;
  logic [7:0] dcfg_r, dcfg_nxt;
  logic [15:0] rsa_r, rsa_nxt;
  logic [15:0] rbc_r, rbc_nxt;
  logic [15:0] laddr_r, laddr_nxt;
  logic [15:0] radr_r, radr_nxt;
  logic [15:0] latch_r, latch_nxt;
  logic [15:0] fwd_r, fwd_nxt;
  logic [3:0] bcnt_r, bcnt_nxt;
  logic bus_request_r, bus_request_nxt;
  logic loc_r, loc_nxt;
  logic issued_r, issued_nxt;
  logic rem_on_r, rem_on_nxt;
  logic rem_rd_r, rem_rd_nxt;
  logic full_r, full_nxt;
  logic preq_r, preq_nxt;
  logic frd_nxt, fwr_nxt;
  logic [7:0] alat_r;
  logic [3:0] sync_r;
  logic wait_r;

  // ******************************
  // Decode
  // ******************************
  wire wide = dcfg_r[DCF_WIDE];
  wire a32 = dcfg_r[DCF_A32];
  wire fill = dcfg_r[DCF_FILL];
  wire [1:0] bsel = dcfg_r[DCF_BHI:DCF_BLO];
  wire [3:0] blen = wide ? BURST_WORDS[bsel] : BURST_BYTES[bsel];
  wire acc_req = avs_read_i | avs_write_i;
  wire slave_ok = (state_r == ST_RESET || state_r == ST_IDLE) && !bus_request_r;
  wire ack_now = acc_req & wait_r & slave_ok & (sync_r == 4'(SYNC_CYC - 1));
  wire wr_fire = avs_write_i & !wait_r;
  wire [7:0] wb = avs_writedata_i[7:0];
  wire shut = reset_i | fifo_error_i | (wr_fire && alat_r == REG_CTRL && wb[CTL_STOP]);
  wire rem_need = rem_on_r && (rem_rd_r ? (!full_r && rbc_r != '0) : full_r);
  wire master = state_r == ST_PAGE || state_r == ST_LOCAL || state_r == ST_REMOTE;
  wire abort = master & !bus_grant_i;
  wire cyc_go = master & bus_grant_i & !issued_r;
  wire cyc_page = state_r == ST_PAGE;
  wire cyc_loc = state_r == ST_LOCAL;
  wire cyc_write = cyc_loc ? fifo_to_mem_i : !rem_rd_r;
  wire [15:0] cyc_addr = cyc_page ? rsa_r : (cyc_loc ? laddr_r : radr_r);
  wire [15:0] cyc_wdata = lane(cyc_loc ? fifo_rdata_i : latch_r, wide);
  wire cyc_done;
  wire [15:0] cyc_rdata;
  wire loc_end = fill ? fifo_last_i : (bcnt_r == 4'h1);
  wire [31:0] rd_mux =
    (alat_r == REG_CTRL) ? {28'h0, rem_rd_r, rem_on_r, state_r != ST_RESET, 1'b0} :
    (alat_r == REG_DCFG) ? {24'h0, dcfg_r} :
    (alat_r == REG_RSA_LO) ? {24'h0, rsa_r[7:0]} :
    (alat_r == REG_RSA_HI) ? {24'h0, rsa_r[15:8]} :
    (alat_r == REG_RBC_LO) ? {24'h0, rbc_r[7:0]} :
    (alat_r == REG_RBC_HI) ? {24'h0, rbc_r[15:8]} :
    (alat_r == REG_LADDR) ? {16'h0, laddr_r} :
    (alat_r == REG_STAT) ? {23'h0, full_r, preq_r, 7'(state_r)} : '0;

  // ******************************
  // Next-state logic
  // ******************************
  always_comb
  begin
    state_nxt = state_r;
    dcfg_nxt = dcfg_r;
    rsa_nxt = rsa_r;
    rbc_nxt = rbc_r;
    laddr_nxt = laddr_r;
    radr_nxt = radr_r;
    latch_nxt = latch_r;
    fwd_nxt = fwd_r;
    bcnt_nxt = bcnt_r;
    bus_request_nxt = bus_request_r;
    loc_nxt = loc_r;
    issued_nxt = issued_r;
    rem_on_nxt = rem_on_r;
    rem_rd_nxt = rem_rd_r;
    full_nxt = full_r;
    preq_nxt = preq_r;
    frd_nxt = 1'b0;
    fwr_nxt = 1'b0;
    // Software writes, byte-wide except the 16-bit REG_LADDR
    if (wr_fire)
    begin
      case (alat_r)
        REG_CTRL:
        begin
          if (wb[CTL_START] && state_r == ST_RESET)
            state_nxt = ST_IDLE;
          if (wb[CTL_RSTART] && state_r != ST_RESET)
          begin
            rem_on_nxt = 1'b1;
            rem_rd_nxt = wb[CTL_RREAD];
            radr_nxt = rsa_r;
            full_nxt = 1'b0;
            preq_nxt = 1'b0;
          end
        end
        REG_DCFG: dcfg_nxt = wb;
        REG_RSA_LO: rsa_nxt[7:0] = wb;
        REG_RSA_HI: rsa_nxt[15:8] = wb;
        REG_RBC_LO: rbc_nxt[7:0] = wb;
        REG_RBC_HI: rbc_nxt[15:8] = wb;
        REG_LADDR: laddr_nxt = avs_writedata_i[15:0];
        default: dcfg_nxt = dcfg_r;
      endcase
    end
    // Arbitration and transfers
    if (cyc_go)
    begin
      issued_nxt = 1'b1;
      frd_nxt = cyc_loc & fifo_to_mem_i;
    end
    case (state_r)
      ST_RESET: bus_request_nxt = 1'b0;
      ST_IDLE:
      begin
        if (fifo_req_i && !ack_now)
        begin
          loc_nxt = 1'b1;
          bcnt_nxt = blen;
          bus_request_nxt = 1'b1;
          state_nxt = ST_WAIT;
        end
        else if (rem_need && !ack_now)
        begin
          loc_nxt = 1'b0;
          bus_request_nxt = 1'b1;
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        issued_nxt = 1'b0;
        if (bus_grant_i)
          state_nxt = a32 ? ST_PAGE : (loc_r ? ST_LOCAL : ST_REMOTE);
      end
      ST_PAGE:
      begin
        if (cyc_done)
        begin
          issued_nxt = 1'b0;
          state_nxt = loc_r ? ST_LOCAL : ST_REMOTE;
        end
      end
      ST_LOCAL:
      begin
        if (cyc_done)
        begin
          issued_nxt = 1'b0;
          laddr_nxt = laddr_r + step(wide);
          bcnt_nxt = bcnt_r - 4'h1;
          if (!fifo_to_mem_i)
          begin
            fwd_nxt = lane(cyc_rdata, wide);
            fwr_nxt = 1'b1;
          end
          if (loc_end)
          begin
            bus_request_nxt = 1'b0;
            state_nxt = ST_DROP;
          end
        end
      end
      ST_REMOTE:
      begin
        if (cyc_done)
        begin
          issued_nxt = 1'b0;
          radr_nxt = radr_r + step(wide);
          rbc_nxt = dec(rbc_r, wide);
          if (rem_rd_r)
          begin
            latch_nxt = lane(cyc_rdata, wide);
            full_nxt = 1'b1;
            preq_nxt = 1'b1;
          end
          else
          begin
            full_nxt = 1'b0;
            if (dec(rbc_r, wide) == '0)
              rem_on_nxt = 1'b0;
          end
          if (fifo_req_i)
          begin
            // Local burst appended, request held
            loc_nxt = 1'b1;
            bcnt_nxt = blen;
            state_nxt = ST_LOCAL;
          end
          else
          begin
            bus_request_nxt = 1'b0;
            state_nxt = ST_DROP;
          end
        end
      end
      ST_DROP:
      begin
        // One low cycle so others may contend
        bus_request_nxt = 1'b0;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_RESET;
    endcase
    if (abort)
    begin
      issued_nxt = 1'b0;
      bus_request_nxt = 1'b0;
      state_nxt = ST_DROP;
    end
    // Remote port handshakes
    if (port_read_ack_i && rem_rd_r && preq_r)
    begin
      preq_nxt = 1'b0;
      full_nxt = 1'b0;
      if (rbc_r == '0)
        rem_on_nxt = 1'b0;
    end
    if (port_write_ack_i && !rem_rd_r && preq_r)
    begin
      latch_nxt = lane(port_wdata_i, wide);
      full_nxt = 1'b1;
      preq_nxt = 1'b0;
    end
    if (rem_on_r && !rem_rd_r && !full_r && !preq_r && rbc_r != '0 && !port_write_ack_i)
      preq_nxt = 1'b1;
    if (shut)
    begin
      state_nxt = ST_RESET;
      bus_request_nxt = 1'b0;
      issued_nxt = 1'b0;
      rem_on_nxt = 1'b0;
      full_nxt = 1'b0;
      preq_nxt = 1'b0;
    end
  end

  // ******************************
  // Registers
  // ******************************
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state_r <= ST_RESET;
      dcfg_r <= DCFG_RST;
      rsa_r <= '0;
      rbc_r <= '0;
      laddr_r <= '0;
      radr_r <= '0;
      latch_r <= '0;
      fwd_r <= '0;
      bcnt_r <= '0;
      bus_request_r <= 1'b0;
      loc_r <= 1'b0;
      issued_r <= 1'b0;
      rem_on_r <= 1'b0;
      rem_rd_r <= 1'b0;
      full_r <= 1'b0;
      preq_r <= 1'b0;
      fifo_rd_o <= 1'b0;
      fifo_wr_o <= 1'b0;
      rx_enable_o <= 1'b0;
      tx_enable_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      dcfg_r <= dcfg_nxt;
      rsa_r <= rsa_nxt;
      rbc_r <= rbc_nxt;
      laddr_r <= laddr_nxt;
      radr_r <= radr_nxt;
      latch_r <= latch_nxt;
      fwd_r <= fwd_nxt;
      bcnt_r <= bcnt_nxt;
      bus_request_r <= bus_request_nxt;
      loc_r <= loc_nxt;
      issued_r <= issued_nxt;
      rem_on_r <= rem_on_nxt;
      rem_rd_r <= rem_rd_nxt;
      full_r <= full_nxt;
      preq_r <= preq_nxt;
      fifo_rd_o <= frd_nxt;
      fifo_wr_o <= fwr_nxt;
      rx_enable_o <= state_nxt != ST_RESET;
      tx_enable_o <= state_nxt != ST_RESET;
    end
  end

  // ******************************
  // Slave answer
  // ******************************
  // Waits out master mode, then a fixed synchronisation delay
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      alat_r <= '0;
      sync_r <= '0;
      wait_r <= 1'b1;
      avs_readdata_o <= '0;
    end
    else
    begin
      if (acc_req && wait_r && sync_r == '0)
        alat_r <= avs_address_i;
      if (!acc_req || !wait_r || !slave_ok)
        sync_r <= '0;
      else if (!ack_now)
        sync_r <= sync_r + 4'h1;
      else
        sync_r <= '0;
      wait_r <= !ack_now;
      if (ack_now)
        avs_readdata_o <= rd_mux;
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign bus_request_o = bus_request_r;
  assign port_request_o = preq_r;
  assign port_rdata_o = latch_r;
  assign fifo_wdata_o = fwd_r;

  // ******************************
  // Bus cycle engine
  // ******************************
  nbm_bus_cycle u_cyc (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i | shut),
    .start_i(cyc_go),
    .abort_i(abort),
    .write_i(cyc_write & !cyc_page),
    .page_i(cyc_page),
    .addr_i(cyc_addr),
    .wdata_i(cyc_wdata),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .ad_i(muxed_addr_data_bus_i),
    .ad_o(muxed_addr_data_bus_o),
    .ad_oe_o(muxed_addr_data_bus_oe_o),
    .ads_lo_o(address_strobe_lower_o),
    .ads_hi_o(address_strobe_upper_o),
    .ads_hi_oe_o(address_strobe_upper_oe_o),
    .mrd_o(memory_read_strobe_o),
    .mwr_o(memory_write_strobe_o)
  );

endmodule

/* design/nbm_pkg.sv */
// Constants and types shared by the bus master and slave logic
package nbm_pkg;

  // ******************************
  // Timing
  // ******************************
  localparam int CLK_NS = 20;
  localparam int SYNC_NS = 60;
  // Least time, so round up
  localparam int SYNC_CYC_DEF = (SYNC_NS + CLK_NS - 1) / CLK_NS;

  // ******************************
  // Widths
  // ******************************
  localparam int AVS_AW = 8;
  localparam int AVS_DW = 32;
  localparam int BUS_W = 16;

  // ******************************
  // Register offsets
  // ******************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DCFG = 8'h04;
  localparam logic [7:0] REG_RSA_LO = 8'h08;
  localparam logic [7:0] REG_RSA_HI = 8'h0c;
  localparam logic [7:0] REG_RBC_LO = 8'h10;
  localparam logic [7:0] REG_RBC_HI = 8'h14;
  localparam logic [7:0] REG_LADDR = 8'h18;
  localparam logic [7:0] REG_STAT = 8'h1c;

  // ******************************
  // Fields and reset values
  // ******************************
  localparam int CTL_STOP = 0;
  localparam int CTL_START = 1;
  localparam int CTL_RSTART = 2;
  localparam int CTL_RREAD = 3;
  localparam int DCF_WIDE = 0;
  localparam int DCF_A32 = 2;
  localparam int DCF_FILL = 4;
  localparam int DCF_BLO = 5;
  localparam int DCF_BHI = 6;
  localparam logic [7:0] DCFG_RST = 8'h00;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [3:0] BURST_WORDS [4] = '{4'h1, 4'h2, 4'h4, 4'h6};
  localparam logic [3:0] BURST_BYTES [4] = '{4'h2, 4'h4, 4'h8, 4'hc};

  // ******************************
  // State types
  // ******************************
  typedef enum logic [6:0] {
    ST_RESET = 7'h01,
    ST_IDLE = 7'h02,
    ST_WAIT = 7'h04,
    ST_PAGE = 7'h08,
    ST_LOCAL = 7'h10,
    ST_REMOTE = 7'h20,
    ST_DROP = 7'h40
  } nbm_state_e;

  typedef enum logic [3:0] {
    PH_T1 = 4'h1,
    PH_T2 = 4'h2,
    PH_T3 = 4'h4,
    PH_T4 = 4'h8
  } nbm_phase_e;

endpackage

/* design/nbm_bus_cycle.sv */
// One T1..T4 cycle on the multiplexed address/data bus
`timescale 1ns/1ns
module nbm_bus_cycle
  import nbm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Request
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic write_i,
  input wire logic page_i,
  input wire logic [nbm_pkg::BUS_W-1:0] addr_i,
  input wire logic [nbm_pkg::BUS_W-1:0] wdata_i,
  output logic done_o,
  output logic [nbm_pkg::BUS_W-1:0] rdata_o,
  // Pins
  input wire logic [nbm_pkg::BUS_W-1:0] ad_i,
  output logic [nbm_pkg::BUS_W-1:0] ad_o,
  output logic ad_oe_o,
  output logic ads_lo_o,
  output logic ads_hi_o,
  output logic ads_hi_oe_o,
  output logic mrd_o,
  output logic mwr_o
);
  import nbm_pkg::*;

  nbm_phase_e phase_r;
  logic busy_r;
  logic wr_r;
  logic [BUS_W-1:0] wd_r;

  // ******************************
  // Cycle sequencer
  // ******************************
  always_ff @(posedge sys_clk_i)
  begin
    done_o <= 1'b0;
    if (reset_i || abort_i)
    begin
      phase_r <= PH_T1;
      busy_r <= 1'b0;
      wr_r <= 1'b0;
      wd_r <= '0;
      ad_o <= '0;
      ad_oe_o <= 1'b0;
      ads_lo_o <= 1'b0;
      ads_hi_o <= 1'b0;
      ads_hi_oe_o <= 1'b0;
      mrd_o <= 1'b0;
      mwr_o <= 1'b0;
      if (reset_i)
        rdata_o <= '0;
    end
    else if (start_i && !busy_r)
    begin
      // T1: address out with its strobe
      phase_r <= PH_T1;
      busy_r <= 1'b1;
      wr_r <= write_i;
      wd_r <= wdata_i;
      ad_o <= addr_i;
      ad_oe_o <= 1'b1;
      ads_lo_o <= !page_i;
      ads_hi_o <= page_i;
      ads_hi_oe_o <= page_i;
    end
    else if (busy_r)
    begin
      case (phase_r)
        PH_T1:
        begin
          phase_r <= PH_T2;
          ads_lo_o <= 1'b0;
          ads_hi_o <= 1'b0;
          ad_o <= wr_r ? wd_r : '0;
          ad_oe_o <= wr_r;
          // Page cycle carries no data strobe
          mrd_o <= !wr_r && !ads_hi_oe_o;
          mwr_o <= wr_r && !ads_hi_oe_o;
        end
        PH_T2: phase_r <= PH_T3;
        PH_T3:
        begin
          phase_r <= PH_T4;
          rdata_o <= ad_i;
          mrd_o <= 1'b0;
          mwr_o <= 1'b0;
        end
        PH_T4:
        begin
          // Upper strobe floats after the first group; pull-down holds it
          busy_r <= 1'b0;
          ad_oe_o <= 1'b0;
          ads_hi_oe_o <= 1'b0;
          done_o <= 1'b1;
        end
        default: phase_r <= PH_T1;
      endcase
    end
  end

endmodule

/* verification/nbm_far_model.sv */
// Arbiter, buffer memory and host port model facing the DMA block
`timescale 1ns/1ns
module nbm_far_model
  import nbm_pkg::*;
(
  // Clock, reset, scenario controls
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic cut_i,
  input wire logic port_dir_rd_i,
  // Arbiter and memory
  input wire logic bus_request_i,
  output logic bus_grant_o,
  input wire logic [nbm_pkg::BUS_W-1:0] ad_i,
  input wire logic ad_oe_i,
  input wire logic ads_lo_i,
  input wire logic mrd_i,
  output logic [nbm_pkg::BUS_W-1:0] ad_o,
  // Host port
  input wire logic port_request_i,
  output logic port_read_ack_o,
  output logic port_write_ack_o
);
  logic [nbm_pkg::BUS_W-1:0] addr_r;
  logic ack_r;
  logic hold_r;
  // Released bus shows the inverse, or the address xor 5a5a under the read strobe, so stale data never passes
  assign ad_o = ad_oe_i ? ad_i : (mrd_i ? (addr_r ^ 16'h5a5a) : ~addr_r);
  assign port_read_ack_o = ack_r & port_dir_rd_i;
  assign port_write_ack_o = ack_r & ~port_dir_rd_i;
  always_ff @(posedge sys_clk_i)
  begin
    // Cut both stalls a grant and withdraws one mid-burst
    bus_grant_o <= bus_request_i & ~cut_i & ~reset_i;
    addr_r <= reset_i ? 16'h0000 : (ads_lo_i ? ad_i : addr_r);
    ack_r <= port_request_i & ~ack_r & ~hold_r & ~reset_i;
    hold_r <= ack_r;
  end
endmodule

/* verification/nbm_dma_sva.sv */
// Port assertions for the DMA block
`timescale 1ns/1ns
module nbm_dma_sva
  import nbm_pkg::*;
#(
  parameter int SYNC_CYC = 3
)
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic bus_request_o,
  input wire logic bus_grant_i,
  input wire logic address_strobe_lower_o,
  input wire logic address_strobe_upper_o,
  input wire logic address_strobe_upper_oe_o,
  input wire logic memory_read_strobe_o,
  input wire logic memory_write_strobe_o,
  input wire logic fifo_error_i,
  input wire logic rx_enable_o,
  input wire logic tx_enable_o,
  input wire logic port_request_o,
  input wire logic port_read_ack_i,
  input wire logic port_write_ack_i
);
  logic [3:0] wait_r;
  logic mem_w;
  assign mem_w = memory_read_strobe_o | memory_write_strobe_o;
  // Cycles the current slave access has waited, saturating
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || !(avs_read_i || avs_write_i))
      wait_r <= 4'h0;
    else if (wait_r != 4'hf)
      wait_r <= wait_r + 4'h1;
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_data_phase;
    mem_w [*2] ##1 !mem_w;
  endsequence
  sequence s_page_phase;
    (address_strobe_upper_oe_o && !mem_w) [*4] ##1 !address_strobe_upper_oe_o;
  endsequence
  a_answer_waits: assert property (!avs_waitrequest_o |-> wait_r >= SYNC_CYC && !bus_request_o)
    else $error("slave answer came too early or while master");
  a_answer_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("slave answer held more than one cycle");
  a_strobe_granted: assert property (address_strobe_lower_o |-> $past(bus_grant_i) && bus_request_o)
    else $error("memory cycle without bus grant");
  a_cycle_four: assert property (disable iff (reset_i || !bus_grant_i) address_strobe_lower_o |=> s_data_phase)
    else $error("memory cycle not four clocks");
  a_page_drive: assert property (disable iff (reset_i || !bus_grant_i) address_strobe_upper_o |-> s_page_phase)
    else $error("upper strobe driven outside page cycle");
  a_reset_quiet: assert property (disable iff (1'b0) reset_i |=> !rx_enable_o && !tx_enable_o && !bus_request_o && !port_request_o && avs_waitrequest_o)
    else $error("outputs not quiet after reset");
  a_error_stops: assert property (fifo_error_i |=> !rx_enable_o && !tx_enable_o && !bus_request_o)
    else $error("fifo error did not stop the block");
  a_ack_drops_port: assert property (port_request_o && (port_read_ack_i || port_write_ack_i) |=> !port_request_o)
    else $error("port request held after acknowledge");
endmodule
bind nbm_dma nbm_dma_sva #(.SYNC_CYC(SYNC_CYC)) u_nbm_dma_sva (.sys_clk_i, .reset_i, .avs_read_i,
  .avs_write_i, .avs_waitrequest_o, .bus_request_o, .bus_grant_i, .address_strobe_lower_o,
  .address_strobe_upper_o, .address_strobe_upper_oe_o, .memory_read_strobe_o,
  .memory_write_strobe_o, .fifo_error_i, .rx_enable_o, .tx_enable_o, .port_request_o,
  .port_read_ack_i, .port_write_ack_i);

/* verification/nbm_dma_test.sv */
// Self-checking bench for the DMA block
`timescale 1ns/1ns
module nbm_dma_test;
  import nbm_pkg::*;
  typedef struct {logic [7:0] dcfg; logic dir; int units; int page;} nbm_row_s;
  nbm_row_s rows [9] = '{'{8'h01, 1'b1, 1, 0}, '{8'h25, 1'b0, 2, 1}, '{8'h41, 1'b1, 4, 0},
    '{8'h65, 1'b0, 6, 1}, '{8'h04, 1'b1, 2, 1}, '{8'h20, 1'b0, 4, 0}, '{8'h44, 1'b1, 8, 1},
    '{8'h60, 1'b0, 12, 0}, '{8'h71, 1'b1, 1, 0}};
  logic sys_clk = 0, rst = 1, rd = 0, wr = 0, wrq, bus_request, grant, adoe, asl, asu, asuoe, memory_read_strobe, memory_write_strobe;
  logic freq = 0, fdir = 0, flast = 0, ferr = 0, rxe, preq, prack, pwack, cut = 0, pdir = 0;
  logic txe, fpop, fpush;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 0, rdata, rdq;
  logic [15:0] adi, ado, fwd, prd, frd = 16'hc3a5, pwd = 16'h3c5a;
  int bad_count = 0, n_checks = 0, n_units = 0, n_pages = 0, n_reqs = 0, n_acks = 0;
  int n_mwr = 0, n_fifo = 0, u0, p0, wk, f0;
  always #10 sys_clk = ~sys_clk;
  nbm_dma u_nbm_dma (.sys_clk_i(sys_clk), .reset_i(rst), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wrq),
    .bus_request_o(bus_request), .bus_grant_i(grant), .muxed_addr_data_bus_i(adi),
    .muxed_addr_data_bus_o(ado), .muxed_addr_data_bus_oe_o(adoe), .address_strobe_lower_o(asl),
    .address_strobe_upper_o(asu), .address_strobe_upper_oe_o(asuoe), .memory_read_strobe_o(memory_read_strobe),
    .memory_write_strobe_o(memory_write_strobe), .fifo_req_i(freq), .fifo_to_mem_i(fdir), .fifo_last_i(flast),
    .fifo_error_i(ferr), .fifo_rdata_i(frd), .fifo_rd_o(fpop), .fifo_wdata_o(fwd),
    .fifo_wr_o(fpush), .rx_enable_o(rxe), .tx_enable_o(txe), .port_request_o(preq),
    .port_read_ack_i(prack), .port_write_ack_i(pwack), .port_wdata_i(pwd), .port_rdata_o(prd));
  nbm_far_model u_nbm_far_model (.sys_clk_i(sys_clk), .reset_i(rst), .cut_i(cut),
    .port_dir_rd_i(pdir), .bus_request_i(bus_request), .bus_grant_o(grant), .ad_i(ado), .ad_oe_i(adoe),
    .ads_lo_i(asl), .mrd_i(memory_read_strobe), .ad_o(adi), .port_request_i(preq), .port_read_ack_o(prack),
    .port_write_ack_o(pwack));
  always @(posedge sys_clk)
  begin
    n_units += asl;
    n_pages += asu;
    n_acks += prack | pwack;
    n_reqs += $rose(bus_request);
    n_mwr += $rose(memory_write_strobe);
    n_fifo += fdir ? fpop : fpush;
  end
  // ****************
  // Bus and check tasks
  // ****************
  task automatic avs(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wd <= d;
    do
    begin
      @(posedge sys_clk);
    end
    while (wrq !== 1'b0);
    rdq = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wait_bus_request(input logic v);
    wk = 0;
    while (bus_request !== v && wk < 300)
    begin
      @(posedge sys_clk);
      wk++;
    end
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic remote(input logic r, input logic [7:0] cnt);
    pdir <= r;
    avs(1'b1, REG_DCFG, 32'h0);
    avs(1'b1, REG_RSA_LO, 32'h40);
    avs(1'b1, REG_RSA_HI, 32'h0);
    avs(1'b1, REG_RBC_LO, {24'h0, cnt});
    avs(1'b1, REG_RBC_HI, 32'h0);
    u0 = n_acks;
    p0 = n_reqs;
    wk = n_mwr;
    avs(1'b1, REG_CTRL, {28'h0, r, 3'h6});
    avs(1'b0, REG_CTRL, 32'h0);
    repeat (40)
      if (rdq[2] !== 1'b0 || rdq[1] !== 1'b1)
        avs(1'b0, REG_CTRL, 32'h0);
    chk("port acks", cnt, n_acks - u0);
    chk("bus requests", cnt, n_reqs - p0);
    chk("stores", r ? 0 : cnt, n_mwr - wk);
    avs(1'b0, REG_RBC_LO, 32'h0);
    chk("count left", 0, rdq[7:0]);
    chk("port request", 1'b0, preq);
    chk("port data", r ? 16'h0018 : 16'h005a, prd);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    bad_count++;
    complete_run;
  end
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    avs(1'b0, REG_STAT, 32'h0);
    chk("reset state", 7'h01, rdq[6:0]);
    chk("rx off", 1'b0, rxe);
    avs(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rdq);
    $display("reset test done");
    foreach (rows[i])
    begin
      avs(1'b1, REG_DCFG, {24'h0, rows[i].dcfg});
      avs(1'b1, REG_LADDR, 32'h100);
      avs(1'b1, REG_CTRL, 32'h2);
      fdir <= rows[i].dir;
      flast <= rows[i].dcfg[DCF_FILL];
      u0 = n_units;
      f0 = n_fifo;
      p0 = n_pages;
      freq <= 1'b1;
      wait_bus_request(1'b1);
      freq <= 1'b0;
      wait_bus_request(1'b0);
      chk("burst units", rows[i].units, n_units - u0);
      chk("page cycles", rows[i].page, n_pages - p0);
      avs(1'b0, REG_LADDR, 32'h0);
      chk("local addr", 16'h100 + rows[i].units * (rows[i].dcfg[0] ? 2 : 1), rdq[15:0]);
      chk("fifo moves", rows[i].units, n_fifo - f0);
    end
    avs(1'b0, REG_STAT, 32'h0);
    chk("back idle", 7'h02, rdq[6:0]);
    chk("fifo data", 16'h0051, fwd);
    $display("burst test done");
    remote(1'b1, 8'h03);
    remote(1'b0, 8'h02);
    $display("remote test done");
    avs(1'b1, REG_DCFG, 32'h60);
    cut <= 1'b1;
    freq <= 1'b1;
    u0 = n_units;
    wait_bus_request(1'b1);
    repeat (3) @(posedge sys_clk);
    cut <= 1'b0;
    while (asl !== 1'b1 && wk < 600)
    begin
      @(posedge sys_clk);
      wk++;
    end
    cut <= 1'b1;
    freq <= 1'b0;
    wait_bus_request(1'b0);
    chk("abort quick", 1'b1, wk <= 4);
    chk("abort short", 1'b1, n_units - u0 < 12);
    cut <= 1'b0;
    avs(1'b1, REG_CTRL, 32'h1);
    avs(1'b0, REG_STAT, 32'h0);
    chk("stop state", 7'h01, rdq[6:0]);
    avs(1'b1, REG_CTRL, 32'h2);
    @(posedge sys_clk);
    chk("running", 1'b1, rxe);
    chk("tx on", 1'b1, txe);
    ferr <= 1'b1;
    @(posedge sys_clk);
    ferr <= 1'b0;
    @(posedge sys_clk);
    chk("error stop", 1'b0, rxe);
    avs(1'b1, REG_CTRL, 32'h2);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("second reset", 1'b0, bus_request);
    avs(1'b0, REG_STAT, 32'h0);
    chk("reset state again", 7'h01, rdq[6:0]);
    $display("abort and stop test done");
    complete_run;
  end
endmodule
